// [src/cst_map.vh]
// constants and register map of the clock source start-up sequencer
// What this block does
// - decode crystal source ranges from fuse field
// - decode internal rc, 128k rc, external clock
// - fuse bit one unprogrammed, zero programmed
// - factory default 0010, startup 10, div8 programmed
// - programmed div8 fuse divides clock by eight
// - hold internal reset time-out after sources release
// - time-out counted on watchdog: 0, 4, 65 ms
// - ripple counter holds reset for start-up cycles
// - reset: time-out plus start-up; wake: start-up only
// - low-power range from source bits two and one
// - low-power bit0 0: 258 cycles, 4/65 ms
// - low-power 1k start-up for three settings
// - low-power bit0 1: 16k start-up settings
`ifndef CST_MAP_VH
`define CST_MAP_VH
`define CST_SRC_LOWPWR   3'd0
`define CST_SRC_FULLSW   3'd1
`define CST_SRC_LOWFREQ  3'd2
`define CST_SRC_RC128K   3'd3
`define CST_SRC_RC       3'd4
`define CST_SRC_EXT      3'd5
`define CST_SRC_RSVD     3'd6
`define CST_DEF_CKSRC    4'h2
`define CST_DEF_STARTUP  2'h2
`define CST_DEF_DIV8     1'b0
`define CST_TO_NONE      2'd0
`define CST_TO_4MS       2'd1
`define CST_TO_65MS      2'd2
`define CST_TO_4MS_US    4000
`define CST_TO_65MS_US   65000
`define CST_WDT_KHZ      128
`define CST_CK_14        16'd14
`define CST_CK_258       16'd258
`define CST_CK_1K        16'd1024
`define CST_CK_16K       16'd16384
`define CST_CK_32K       16'd32768
`define CST_CK_EXT       16'd6
`define CST_DIV8         3'd7
`define CST_REG_FUSE     32'h00
`define CST_REG_STATUS   32'h04
`define CST_REG_CTRL     32'h08
`endif

// [src/cst_startup.v]
// clock source selection and internal reset start-up sequencer
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "cst_map.vh"
module cst_startup #(
  parameter integer WDT_4MS_CYCLES  = 512,
  parameter integer WDT_65MS_CYCLES = 8320
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        ext_reset_active,
  input  wire        wake_request,
  input  wire        wdt_osc_tick,
  input  wire        osc_tick,
  output wire        internal_reset,
  output reg         sys_clk_enable,
  output reg  [2:0]  clock_source_kind,
  output reg  [1:0]  lowpwr_range,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);
  localparam [3:0] ST_RESET   = 4'b0001;
  localparam [3:0] ST_TIMEOUT = 4'b0010;
  localparam [3:0] ST_STARTUP = 4'b0100;
  localparam [3:0] ST_RUN     = 4'b1000;
  reg [3:0] state_q;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  // two flops on ext_reset_active, wake_request and both ticks; only the second stage feeds logic
  reg [1:0] ext_rst_s_q;
  reg [1:0] wake_s_q;
  reg [1:0] wdt_s_q;
  reg [1:0] osc_s_q;
  // prev flops reset low, so a tick already high at release counts as an edge once through the synchronisers
  reg       wdt_prev_q;
  reg       osc_prev_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      ext_rst_s_q <= 2'b11;
      wake_s_q    <= 2'b00;
      wdt_s_q     <= 2'b00;
      osc_s_q     <= 2'b00;
      wdt_prev_q  <= 1'b0;
      osc_prev_q  <= 1'b0;
    end else begin
      ext_rst_s_q <= {ext_rst_s_q[0], ext_reset_active};
      wake_s_q    <= {wake_s_q[0], wake_request};
      wdt_s_q     <= {wdt_s_q[0], wdt_osc_tick};
      osc_s_q     <= {osc_s_q[0], osc_tick};
      wdt_prev_q  <= wdt_s_q[1];
      osc_prev_q  <= osc_s_q[1];
    end
  end
  wire ext_rst  = ext_rst_s_q[1];
  wire wake     = wake_s_q[1];
  wire wdt_rise = wdt_s_q[1] & ~wdt_prev_q;
  wire osc_rise = osc_s_q[1] & ~osc_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // fuse registers: zero means programmed
  reg [3:0] clock_source_select_fuses_q;
  reg [1:0] startup_time_fuses_q;
  reg       divide_by_eight_fuse_q;
  wire      startup_select_low_bit = clock_source_select_fuses_q[0];

  function [2:0] src_kind;
    input [3:0] sel;
    begin
      if (sel[3])                src_kind = `CST_SRC_LOWPWR;
      else if (sel[3:1] == 3'h3) src_kind = `CST_SRC_FULLSW;
      else if (sel[3:1] == 3'h2) src_kind = `CST_SRC_LOWFREQ;
      else if (sel == 4'h3)      src_kind = `CST_SRC_RC128K;
      else if (sel == 4'h2)      src_kind = `CST_SRC_RC;
      else if (sel == 4'h0)      src_kind = `CST_SRC_EXT;
      else                       src_kind = `CST_SRC_RSVD;
    end
  endfunction

  // start-up cycles and time-out for the crystal tables; other sources
  // use a short fixed start-up and the time-out coded by the startup fuses
  reg [15:0] su_cycles;
  reg [1:0]  to_sel;
  always @* begin
    su_cycles = `CST_CK_EXT;
    to_sel    = startup_time_fuses_q;
    if (to_sel == 2'd3)
      to_sel = `CST_TO_NONE;
    if (clock_source_kind == `CST_SRC_LOWPWR ||
        clock_source_kind == `CST_SRC_FULLSW) begin
      // bit zero of the source field picks the half of the table
      case ({startup_select_low_bit, startup_time_fuses_q})
        3'b000: begin
          su_cycles = `CST_CK_258;
          to_sel    = `CST_TO_4MS;
        end
        3'b001: begin
          su_cycles = `CST_CK_258;
          to_sel    = `CST_TO_65MS;
        end
        3'b010: begin
          su_cycles = `CST_CK_1K;
          to_sel    = `CST_TO_NONE;
        end
        3'b011: begin
          su_cycles = `CST_CK_1K;
          to_sel    = `CST_TO_4MS;
        end
        3'b100: begin
          su_cycles = `CST_CK_1K;
          to_sel    = `CST_TO_65MS;
        end
        3'b101: begin
          su_cycles = `CST_CK_16K;
          to_sel    = `CST_TO_NONE;
        end
        3'b110: begin
          su_cycles = `CST_CK_16K;
          to_sel    = `CST_TO_4MS;
        end
        default: begin
          su_cycles = `CST_CK_16K;
          to_sel    = `CST_TO_65MS;
        end
      endcase
    end else if (clock_source_kind == `CST_SRC_LOWFREQ) begin
      su_cycles = startup_select_low_bit ? `CST_CK_32K : `CST_CK_1K;
      to_sel    = startup_time_fuses_q == 2'd3 ? `CST_TO_NONE
                                                : startup_time_fuses_q;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      clock_source_kind <= `CST_SRC_RC;
      lowpwr_range      <= 2'd0;
    end else if (state_q == ST_RESET) begin
      // latched per reset start: a fuse write mid-run waits for the next reset, not a wake
      clock_source_kind <= src_kind(clock_source_select_fuses_q);
      lowpwr_range      <= clock_source_select_fuses_q[2:1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset sequencer
  reg [15:0] wdt_cnt_q;
  reg [15:0] osc_cnt_q;
  reg [2:0]  div_q;
  reg        from_reset_q;
  wire [15:0] to_target = (to_sel == `CST_TO_4MS)  ? WDT_4MS_CYCLES[15:0] :
                          (to_sel == `CST_TO_65MS) ? WDT_65MS_CYCLES[15:0] :
                          16'd0;
  // reset adds 14 start-up cycles after the oscillator count
  wire [15:0] su_target = from_reset_q ? su_cycles + `CST_CK_14 : su_cycles;
  // a zero target skips the time-out, as brown-out guarded boards want
  wire        timeout_done = (wdt_cnt_q >= to_target);
  wire        startup_done = (osc_cnt_q >= su_target);

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q      <= ST_RESET;
      wdt_cnt_q    <= 16'd0;
      osc_cnt_q    <= 16'd0;
      from_reset_q <= 1'b1;
    end else if (ext_rst) begin
      state_q      <= ST_RESET;
      wdt_cnt_q    <= 16'd0;
      osc_cnt_q    <= 16'd0;
      from_reset_q <= 1'b1;
    end else begin
      case (state_q)
        ST_RESET: begin
          state_q <= ST_TIMEOUT;
        end
        ST_TIMEOUT: begin
          if (timeout_done)
            state_q <= ST_STARTUP;
          else if (wdt_rise)
            wdt_cnt_q <= wdt_cnt_q + 16'd1;
        end
        ST_STARTUP: begin
          if (startup_done)
            state_q <= ST_RUN;
          else if (osc_rise)
            osc_cnt_q <= osc_cnt_q + 16'd1;
        end
        ST_RUN: begin
          // wake skips the time-out: the supply is assumed good already
          if (wake) begin
            state_q      <= ST_STARTUP;
            osc_cnt_q    <= 16'd0;
            from_reset_q <= 1'b0;
          end
        end
        default: state_q <= ST_RESET;
      endcase
    end
  end
  assign internal_reset = (state_q != ST_RUN) | ext_rst;

  ////////////////////////////////////////////////////////////////////////////
  // system clock enable, divided by eight when the fuse is programmed
  // the pulse flop lags the sequencer by one edge, so the output is
  // masked with internal_reset to gate downstream logic at once
  reg sys_clk_en_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      div_q        <= 3'd0;
      sys_clk_en_q <= 1'b0;
    end else if (state_q != ST_RUN) begin
      div_q        <= 3'd0;
      sys_clk_en_q <= 1'b0;
    end else if (osc_rise) begin
      if (!divide_by_eight_fuse_q) begin
        div_q        <= div_q + 3'd1;
        sys_clk_en_q <= (div_q == `CST_DIV8);
      end else begin
        sys_clk_en_q <= 1'b1;
      end
    end else begin
      sys_clk_en_q <= 1'b0;
    end
  end
  always @* begin
    sys_clk_enable = sys_clk_en_q & ~internal_reset;
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  reg        aw_q;
  reg        w_q;
  reg [31:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0]  wstrb_q;
  assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  // address and data may come in either order; the answer waits for both
  wire do_write = aw_q & w_q;

  // byte lanes below a word are ignored, as every register is one word
  function fuse_hit;
    input [31:0] addr;
    begin
      fuse_hit = (addr[31:2] == (`CST_REG_FUSE >> 2));
    end
  endfunction

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 32'h0;
      wdata_q  <= 32'h0;
      wstrb_q  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
      clock_source_select_fuses_q <= `CST_DEF_CKSRC;
      startup_time_fuses_q        <= `CST_DEF_STARTUP;
      divide_by_eight_fuse_q      <= `CST_DEF_DIV8;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_q         <= 1'b0;
        w_q          <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'b00;
        if (fuse_hit(awaddr_q)) begin
          if (wstrb_q[0]) begin
            clock_source_select_fuses_q <= wdata_q[3:0];
            startup_time_fuses_q        <= wdata_q[5:4];
            divide_by_eight_fuse_q      <= wdata_q[7];
          end
        end else begin
          s_axi_bresp <= 2'b10;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'b00;
      case (s_axi_araddr)
        `CST_REG_FUSE:
          s_axi_rdata <= {24'h0,
                          divide_by_eight_fuse_q,
                          1'b1,
                          startup_time_fuses_q,
                          clock_source_select_fuses_q};
        `CST_REG_STATUS:
          s_axi_rdata <= {21'h0,
                          lowpwr_range,
                          clock_source_kind,
                          from_reset_q,
                          internal_reset,
                          state_q};
        // unmapped reads answer an error with zero data
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // cst_startup
`default_nettype wire

// [sim/cst_osc_model.sv]
// free-running oscillator models for the sequencer inputs
`timescale 1ns/100ps
`default_nettype none
module cst_osc_model (
  output var logic osc_tick,
  output var logic wdt_osc_tick
);
  // periods unrelated to aclk so the synchronisers see real skew
  initial begin
    osc_tick = 1'b0;
    forever #210 osc_tick = ~osc_tick;
  end
  initial begin
    wdt_osc_tick = 1'b0;
    forever #430 wdt_osc_tick = ~wdt_osc_tick;
  end
endmodule // cst_osc_model
`default_nettype wire

// [sim/cst_startup_props.sv]
// port assertions of the start-up sequencer
`timescale 1ns/100ps
`default_nettype none
module cst_startup_props #(
  parameter integer WDT_4MS_CYCLES  = 512,
  parameter integer WDT_65MS_CYCLES = 8320
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ext_reset_active,
  input wire logic        internal_reset,
  input wire logic        sys_clk_enable,
  input wire logic [2:0]  clock_source_kind,
  input wire logic [1:0]  lowpwr_range,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_write_refused: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer lost");
  a_ext_holds: assert property (ext_reset_active[*3] |->
    internal_reset) else $error("reset not held");
  // two sync stages plus a start-up count always exceed eight cycles
  a_hold_min: assert property ($fell(ext_reset_active) |=>
    internal_reset[*8]) else $error("reset released early");
  a_clk_gated: assert property (internal_reset |->
    !sys_clk_enable) else $error("clock runs in reset");
  a_cfg_stable: assert property (
    !internal_reset && !$past(internal_reset) |->
    $stable(clock_source_kind) && $stable(lowpwr_range))
    else $error("source changed while running");
  a_kind_legal: assert property (clock_source_kind <= 3'h6)
    else $error("bad source kind");
  a_clk_pulse: assert property (sys_clk_enable |=>
    !sys_clk_enable) else $error("clock pulse too long");
endmodule // cst_startup_props
bind cst_startup cst_startup_props #(
  .WDT_4MS_CYCLES(WDT_4MS_CYCLES), .WDT_65MS_CYCLES(WDT_65MS_CYCLES)
) u_props (
  .aclk, .aresetn, .ext_reset_active, .internal_reset, .sys_clk_enable,
  .clock_source_kind, .lowpwr_range, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata
);
`default_nettype wire

// [sim/testbench.sv]
// self-checking bench for the start-up sequencer
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        aclk, aresetn, ext_reset_active, wake_request;
  wire         osc_tick, wdt_osc_tick, internal_reset, sys_clk_enable;
  wire   [2:0] clock_source_kind;
  wire   [1:0] lowpwr_range, bresp, rresp;
  wire         awready, wready, bvalid, arready, rvalid;
  wire  [31:0] rdata;
  logic [31:0] awaddr, wdata, araddr, seed, v;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [33:0] expq[$];
  int          bad_count, n_checks, cyc, n;

  cst_osc_model u_osc (.osc_tick, .wdt_osc_tick);
  cst_startup #(.WDT_4MS_CYCLES(2), .WDT_65MS_CYCLES(8)) uut (
    .aclk, .aresetn, .ext_reset_active, .wake_request, .wdt_osc_tick,
    .osc_tick, .internal_reset, .sys_clk_enable, .clock_source_kind,
    .lowpwr_range, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [33:0] e, s);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic rng(input string nm, input int lo, hi, s);
    n_checks++;
    if (s < lo || s > hi) begin
      bad_count++;
      $display("[FAIL] %s exp %0d..%0d got %0d", nm, lo, hi, s);
    end
  endtask
  task automatic axw(input logic [31:0] a, d);
    logic aw, w;
    @(posedge aclk);
    {aw, w} = 2'b11;
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    while (aw || w) begin
      @(posedge aclk);
      aw &= !awready;
      w &= !wready;
      {awvalid, wvalid} <= {aw, w};
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    chk("bresp", 34'h0, 34'(bresp));
  endtask
  task automatic axr(input logic [31:0] a, input logic [33:0] e, int slow);
    expq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    // a late rready makes the slave hold its answer
    repeat (slow) @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (!(rvalid && rready));
    rready <= 1'b0;
  endtask
  task automatic kick();
    ext_reset_active <= 1'b1;
    repeat (4) @(posedge aclk);
    ext_reset_active <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic wait_for(input logic lvl);
    n = 0;
    while (((lvl ? sys_clk_enable : internal_reset) !== lvl) && n < 400)
    begin
      @(posedge aclk);
      n++;
    end
  endtask
  function automatic logic [33:0] kind_of(input int c);
    if (c > 7) return 0;
    if (c > 5) return 1;
    if (c > 3) return 2;
    return c == 3 ? 3 : c == 2 ? 4 : c == 0 ? 5 : 6;
  endfunction
  task automatic report_and_stop();
    if (bad_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge aclk)
    if (rvalid && rready) chk("rdata", expq.pop_front(), {rresp, rdata});
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial begin
    seed = 32'hcac5d9d6;
    {aresetn, wake_request, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr} = '0;
    ext_reset_active = 1'b1;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(32'h00, 34'h62, 0);
    axr(32'h0c, 34'h200000000, 2);
    v = $random(seed);
    axw(32'h00, v);
    axr(32'h00, {26'h0, v[7], 1'b1, v[5:0]}, 1);
    for (int c = 0; c < 16; c++) begin
      axw(32'h00, 32'h70 | c);
      kick();
      repeat (10) @(posedge aclk);
      chk("kind", kind_of(c), 34'(clock_source_kind));
      if (c > 7) chk("range", 34'(c[2:1]), 34'(lowpwr_range));
    end
    // default fuses keep the time-out, as a board without brown-out needs
    axw(32'h00, 32'h22);
    kick();
    wait_for(1'b0);
    rng("reset len", 145, 185, n);
    wait_for(1'b1);
    n = 0;
    repeat (336) begin
      @(posedge aclk);
      n += sys_clk_enable;
    end
    rng("div8 on", 9, 11, n);
    axw(32'h00, 32'ha2);
    n = 0;
    repeat (336) begin
      @(posedge aclk);
      n += sys_clk_enable;
    end
    rng("div8 off", 78, 82, n);
    // running, full start, rc source, range bits 01
    axr(32'h04, 34'h328, 0);
    wake_request <= 1'b1;
    repeat (3) @(posedge aclk);
    wake_request <= 1'b0;
    // let the synchronised wake reach the sequencer before timing it
    repeat (2) @(posedge aclk);
    chk("wake rst", 34'h1, 34'(internal_reset));
    n = 0;
    wait_for(1'b1);
    rng("wake len", 15, 35, n);
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
